/* File: logic/uab_pkg.sv */
package uab_pkg;

  // register byte addresses on the 32-bit slave port
  localparam logic [5:0] ADDR_PERIPHERAL_FLAGS_1       = 6'h00;
  localparam logic [5:0] ADDR_PERIPHERAL_IRQ_ENABLE_1  = 6'h04;
  localparam logic [5:0] ADDR_RECEIVE_STATUS_CONTROL   = 6'h08;
  localparam logic [5:0] ADDR_TRANSMIT_BUFFER          = 6'h0C;
  localparam logic [5:0] ADDR_TRANSMIT_STATUS_CONTROL  = 6'h10;
  localparam logic [5:0] ADDR_BAUD_CONTROL             = 6'h14;
  localparam logic [5:0] ADDR_BAUD_DIVISOR_HIGH        = 6'h18;
  localparam logic [5:0] ADDR_BAUD_DIVISOR_LOW         = 6'h1C;
  localparam logic [5:0] ADDR_RECEIVE_BUFFER           = 6'h20;

  // peripheral_flags_1 / peripheral_irq_enable_1
  localparam int BIT_RECEIVE_DONE     = 5;
  localparam int BIT_TX_BUFFER_EMPTY  = 4;
  // receive_status_control
  localparam int BIT_PORT_ENABLE      = 7;
  localparam int BIT_NINE_BIT_RECEIVE = 6;
  // transmit_status_control
  localparam int BIT_NINE_BIT_TX      = 6;
  localparam int BIT_TRANSMIT_ENABLE  = 5;
  localparam int BIT_SYNC_MODE        = 4;
  localparam int BIT_HIGH_SPEED       = 2;
  localparam int BIT_SHIFTER_EMPTY    = 1;
  localparam int BIT_NINTH_TX         = 0;
  // baud_control
  localparam int BIT_AUTOBAUD_OVF     = 7;
  localparam int BIT_RECEIVE_POL      = 5;
  localparam int BIT_TRANSMIT_POL     = 4;
  localparam int BIT_WIDE_DIVISOR     = 3;
  localparam int BIT_WAKE_ON_EDGE     = 1;
  localparam int BIT_AUTOBAUD_ENABLE  = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // oscillator clocks per generator count in normal operation
  localparam logic [8:0] PRESCALE_SLOW = 9'h040;
  localparam logic [8:0] PRESCALE_MID  = 9'h010;
  localparam logic [8:0] PRESCALE_FAST = 9'h004;
  // measurement counts eight times slower
  localparam int MEASURE_SHIFT = 3;
  localparam logic [2:0] AUTOBAUD_EDGES = 3'h5;

  localparam int FRAME_BITS_MAX = 11;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } uab_avs_req_s;

  typedef enum logic [1:0] {
    ABD_IDLE,
    ABD_WAIT_START,
    ABD_WAIT_RISE,
    ABD_COUNT
  } uab_abd_state_e;

endpackage

/* File: logic/uab_top.sv */
`timescale 1ns/100ps

module uab_top
  import uab_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  input  wire uab_pkg::uab_avs_req_s AVS_REQ,
  output logic [31:0]                AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic                  RECEIVE_LINE,
  output logic                       TRANSMIT_LINE
);
  import uab_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT
  } uab_tx_state_e;

  logic           ack;
  logic           bus_req;
  logic           wr_en;
  logic           rd_take;
  logic [7:0]     wbyte;
  logic [7:0]     flags_irq_enable;
  logic           receive_done_flag;
  logic           tx_buffer_empty_flag;
  logic           port_enable;
  logic           nine_bit_receive;
  logic [7:0]     transmit_buffer;
  logic           buffer_full;
  logic           nine_bit_transmit;
  logic           transmit_enable;
  logic           sync_mode;
  logic           high_speed_select;
  logic           ninth_transmit_bit;
  logic           autobaud_overflow;
  logic           receive_polarity;
  logic           transmit_polarity;
  logic           wide_divisor_mode;
  logic           wake_on_edge_enable;
  logic           autobaud_enable;
  logic [7:0]     divisor_high_byte;
  logic [7:0]     divisor_low_byte;
  logic           rx_meta;
  logic           rx_sync;
  logic           rx_prev;
  logic           rx_level;
  logic           rx_fall;
  logic           rx_rise;
  logic           wake_armed;
  uab_abd_state_e abd_state;
  logic [2:0]     rise_count;
  logic [15:0]    measure_count;
  logic           abd_start;
  logic           abd_done;
  logic           abd_run;
  logic [11:0]    pre_cnt;
  logic [11:0]    pre_limit;
  logic           pre_tick;
  logic [15:0]    gen_cnt;
  logic [15:0]    divisor;
  logic           bit_tick;
  uab_tx_state_e  tx_state;
  logic [10:0]    tx_shift;
  logic [3:0]     tx_bits_left;
  logic           load_shifter;
  logic           tx_level;
  logic [7:0]     next_read;

  function automatic logic [8:0] counter_prescale(input logic wide, input logic fast);
    if (wide && fast)
      counter_prescale = PRESCALE_FAST;
    else if (wide || fast)
      counter_prescale = PRESCALE_MID;
    else
      counter_prescale = PRESCALE_SLOW;
  endfunction

  // one wait cycle, then the answer
  assign bus_req         = AVS_REQ.read | AVS_REQ.write;
  assign AVS_WAITREQUEST = bus_req & ~ack;
  assign wr_en           = AVS_REQ.write & ack & AVS_REQ.byteenable[0];
  assign rd_take         = AVS_REQ.read & ack;
  assign wbyte           = AVS_REQ.writedata[7:0];

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      ack <= 1'b0;
    else
      ack <= bus_req & ~ack;
  end

  always_comb
  begin
    next_read = 8'h00;
    unique case (AVS_REQ.address)
      ADDR_PERIPHERAL_FLAGS_1:
      begin
        next_read[BIT_RECEIVE_DONE]    = receive_done_flag;
        next_read[BIT_TX_BUFFER_EMPTY] = tx_buffer_empty_flag;
      end
      ADDR_PERIPHERAL_IRQ_ENABLE_1: next_read = flags_irq_enable;
      ADDR_RECEIVE_STATUS_CONTROL:
      begin
        next_read[BIT_PORT_ENABLE]      = port_enable;
        next_read[BIT_NINE_BIT_RECEIVE] = nine_bit_receive;
      end
      ADDR_TRANSMIT_BUFFER:         next_read = transmit_buffer;
      ADDR_TRANSMIT_STATUS_CONTROL:
      begin
        next_read[BIT_NINE_BIT_TX]     = nine_bit_transmit;
        next_read[BIT_TRANSMIT_ENABLE] = transmit_enable;
        next_read[BIT_SYNC_MODE]       = sync_mode;
        next_read[BIT_HIGH_SPEED]      = high_speed_select;
        next_read[BIT_SHIFTER_EMPTY]   = (tx_state == TX_IDLE);
        next_read[BIT_NINTH_TX]        = ninth_transmit_bit;
      end
      ADDR_BAUD_CONTROL:
      begin
        next_read[BIT_AUTOBAUD_OVF]    = autobaud_overflow;
        next_read[BIT_RECEIVE_POL]     = receive_polarity;
        next_read[BIT_TRANSMIT_POL]    = transmit_polarity;
        next_read[BIT_WIDE_DIVISOR]    = wide_divisor_mode;
        next_read[BIT_WAKE_ON_EDGE]    = wake_on_edge_enable;
        next_read[BIT_AUTOBAUD_ENABLE] = autobaud_enable;
      end
      ADDR_BAUD_DIVISOR_HIGH:       next_read = divisor_high_byte;
      ADDR_BAUD_DIVISOR_LOW:        next_read = divisor_low_byte;
      default:                      next_read = 8'h00;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_REQ.read && !ack)
      AVS_READDATA <= {24'h00_0000, next_read};
  end

  // plain control registers
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      flags_irq_enable  <= RESET_BYTE;
      port_enable       <= 1'b0;
      nine_bit_receive  <= 1'b0;
      nine_bit_transmit <= 1'b0;
      transmit_enable   <= 1'b0;
      sync_mode         <= 1'b0;
      high_speed_select <= 1'b0;
      ninth_transmit_bit <= 1'b0;
      receive_polarity  <= 1'b0;
      transmit_polarity <= 1'b0;
      wide_divisor_mode <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (AVS_REQ.address)
        ADDR_PERIPHERAL_IRQ_ENABLE_1: flags_irq_enable <= wbyte;
        ADDR_RECEIVE_STATUS_CONTROL:
        begin
          port_enable      <= wbyte[BIT_PORT_ENABLE];
          nine_bit_receive <= wbyte[BIT_NINE_BIT_RECEIVE];
        end
        ADDR_TRANSMIT_STATUS_CONTROL:
        begin
          nine_bit_transmit  <= wbyte[BIT_NINE_BIT_TX];
          transmit_enable    <= wbyte[BIT_TRANSMIT_ENABLE];
          sync_mode          <= wbyte[BIT_SYNC_MODE];
          high_speed_select  <= wbyte[BIT_HIGH_SPEED];
          ninth_transmit_bit <= wbyte[BIT_NINTH_TX];
        end
        ADDR_BAUD_CONTROL:
        begin
          receive_polarity  <= wbyte[BIT_RECEIVE_POL];
          transmit_polarity <= wbyte[BIT_TRANSMIT_POL];
          wide_divisor_mode <= wbyte[BIT_WIDE_DIVISOR];
        end
        default: ;
      endcase
    end
  end

  // receive line: two flops, then polarity and edges
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= RECEIVE_LINE;
      rx_sync <= rx_meta;
      rx_prev <= rx_level;
    end
  end

  assign rx_level = rx_sync ^ receive_polarity;
  assign rx_fall  = rx_prev & ~rx_level;
  assign rx_rise  = ~rx_prev & rx_level;

  // wake enable clears itself on the rise that ends the break
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      wake_on_edge_enable <= 1'b0;
      wake_armed          <= 1'b0;
    end
    else if (wr_en && AVS_REQ.address == ADDR_BAUD_CONTROL)
    begin
      wake_on_edge_enable <= wbyte[BIT_WAKE_ON_EDGE];
      wake_armed          <= 1'b0;
    end
    else if (wake_on_edge_enable)
    begin
      if (rx_fall)
        wake_armed <= 1'b1;
      else if (wake_armed && rx_rise)
      begin
        wake_on_edge_enable <= 1'b0;
        wake_armed          <= 1'b0;
      end
    end
  end

  assign abd_start = wr_en && AVS_REQ.address == ADDR_BAUD_CONTROL
                     && wbyte[BIT_AUTOBAUD_ENABLE] && !autobaud_enable;
  assign abd_run   = autobaud_enable & ~sync_mode & ~wake_on_edge_enable;
  assign abd_done  = abd_run && abd_state == ABD_COUNT && rx_rise
                     && rise_count == AUTOBAUD_EDGES - 3'h1;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      autobaud_enable <= 1'b0;
    else if (abd_done)
      autobaud_enable <= 1'b0;
    else if (wr_en && AVS_REQ.address == ADDR_BAUD_CONTROL)
      autobaud_enable <= wbyte[BIT_AUTOBAUD_ENABLE];
  end

  // measurement state machine
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      abd_state  <= ABD_IDLE;
      rise_count <= 3'h0;
    end
    else if (abd_start)
    begin
      abd_state  <= ABD_WAIT_START;
      rise_count <= 3'h0;
    end
    else if (!autobaud_enable)
      abd_state <= ABD_IDLE;
    else if (abd_run)
    begin
      unique case (abd_state)
        ABD_IDLE:       abd_state <= ABD_WAIT_START;
        ABD_WAIT_START: if (rx_fall) abd_state <= ABD_WAIT_RISE;
        ABD_WAIT_RISE:
          if (rx_rise)
          begin
            abd_state  <= ABD_COUNT;
            rise_count <= 3'h1;
          end
        ABD_COUNT:
          if (rx_rise)
          begin
            rise_count <= rise_count + 3'h1;
            if (abd_done)
              abd_state <= ABD_IDLE;
          end
      endcase
    end
  end

  // prescaler: normal rate, or eight times slower while measuring
  assign pre_limit = (abd_state == ABD_COUNT)
                     ? {counter_prescale(wide_divisor_mode, high_speed_select),
                        3'b000}
                     : {3'b000, counter_prescale(wide_divisor_mode, high_speed_select)};
  assign pre_tick  = (pre_cnt >= pre_limit - 12'h001);

  always_ff @(posedge CLK)
  begin
    // a load restarts the bit timing so the start bit gets a full period
    if (!RSTN || abd_start || load_shifter)
      pre_cnt <= 12'h000;
    else if (pre_tick)
      pre_cnt <= 12'h000;
    else
      pre_cnt <= pre_cnt + 12'h001;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN || abd_start)
      measure_count <= 16'h0000;
    else if (abd_run && abd_state == ABD_COUNT && pre_tick)
      measure_count <= measure_count + 16'h0001;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      autobaud_overflow <= 1'b0;
    else if (abd_run && abd_state == ABD_COUNT && pre_tick && measure_count == 16'hFFFF)
      autobaud_overflow <= 1'b1;
    else if (wr_en && AVS_REQ.address == ADDR_BAUD_CONTROL)
      autobaud_overflow <= wbyte[BIT_AUTOBAUD_OVF];
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      divisor_high_byte <= RESET_BYTE;
      divisor_low_byte  <= RESET_BYTE;
    end
    else if (abd_done)
    begin
      divisor_high_byte <= measure_count[15:8];
      divisor_low_byte  <= measure_count[7:0];
    end
    else if (wr_en && AVS_REQ.address == ADDR_BAUD_DIVISOR_HIGH)
      divisor_high_byte <= wbyte;
    else if (wr_en && AVS_REQ.address == ADDR_BAUD_DIVISOR_LOW)
      divisor_low_byte <= wbyte;
  end

  // receiver stays idle; only the done flag is kept
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      receive_done_flag <= 1'b0;
    else if (abd_done)
      receive_done_flag <= 1'b1;
    else if (rd_take && AVS_REQ.address == ADDR_RECEIVE_BUFFER)
      receive_done_flag <= 1'b0;
  end

  // generator: one bit period per divisor+1 counts
  assign divisor  = wide_divisor_mode ? {divisor_high_byte, divisor_low_byte}
                                      : {8'h00, divisor_low_byte};
  assign bit_tick = pre_tick && gen_cnt == 16'h0000 && !autobaud_enable;

  always_ff @(posedge CLK)
  begin
    if (!RSTN || abd_start || autobaud_enable)
      gen_cnt <= 16'h0000;
    else if (load_shifter)
      gen_cnt <= divisor;
    else if (pre_tick)
      gen_cnt <= (gen_cnt == 16'h0000) ? divisor : gen_cnt - 16'h0001;
  end

  // transmit buffer and shifter
  assign load_shifter = tx_state == TX_IDLE && buffer_full && transmit_enable
                        && port_enable && !sync_mode;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      transmit_buffer <= RESET_BYTE;
      buffer_full     <= 1'b0;
    end
    else if (wr_en && AVS_REQ.address == ADDR_TRANSMIT_BUFFER)
    begin
      transmit_buffer <= wbyte;
      buffer_full     <= 1'b1;
    end
    else if (load_shifter)
      buffer_full <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      tx_buffer_empty_flag <= 1'b0;
    else if (load_shifter)
      tx_buffer_empty_flag <= 1'b1;
    else if (wr_en && AVS_REQ.address == ADDR_TRANSMIT_STATUS_CONTROL
             && wbyte[BIT_TRANSMIT_ENABLE] && !transmit_enable)
      tx_buffer_empty_flag <= 1'b1;
    else if (wr_en && AVS_REQ.address == ADDR_TRANSMIT_BUFFER)
      tx_buffer_empty_flag <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN || !port_enable)
    begin
      tx_state     <= TX_IDLE;
      tx_shift     <= '1;
      tx_bits_left <= 4'h0;
    end
    else
    begin
      unique case (tx_state)
        TX_IDLE:
          if (load_shifter)
          begin
            tx_state <= TX_SHIFT;
            // stop, ninth, data LSB first, start; no parity generated
            tx_shift <= nine_bit_transmit
                        ? {1'b1, ninth_transmit_bit, transmit_buffer, 1'b0}
                        : {2'b11, transmit_buffer, 1'b0};
            tx_bits_left <= nine_bit_transmit ? 4'(FRAME_BITS_MAX) : 4'(FRAME_BITS_MAX - 1);
          end
        TX_SHIFT:
          if (bit_tick)
          begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits_left <= tx_bits_left - 4'h1;
            if (tx_bits_left == 4'h1)
              tx_state <= TX_IDLE;
          end
      endcase
    end
  end

  assign tx_level = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      TRANSMIT_LINE <= 1'b1;
    else
      TRANSMIT_LINE <= tx_level ^ transmit_polarity;
  end

endmodule

/* File: tb/uab_props.sv */
`timescale 1ns/100ps
module uab_props
  import uab_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  RSTN,
  input wire uab_pkg::uab_avs_req_s AVS_REQ,
  input wire logic [31:0]           AVS_READDATA,
  input wire logic                  AVS_WAITREQUEST,
  input wire logic                  RECEIVE_LINE,
  input wire logic                  TRANSMIT_LINE
);
  logic       rq;
  logic       rdone;
  logic       wdone;
  logic [7:0] sh_ien;
  logic [7:0] sh_baud;

  assign rq    = AVS_REQ.read | AVS_REQ.write;
  assign rdone = AVS_REQ.read & ~AVS_WAITREQUEST;
  assign wdone = AVS_REQ.write & ~AVS_WAITREQUEST & AVS_REQ.byteenable[0];

  // shadow of the plain read-write bytes as software wrote them
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sh_ien  <= 8'h00;
      sh_baud <= 8'h00;
    end
    else if (wdone && AVS_REQ.address == ADDR_PERIPHERAL_IRQ_ENABLE_1)
      sh_ien <= AVS_REQ.writedata[7:0];
    else if (wdone && AVS_REQ.address == ADDR_BAUD_CONTROL)
      sh_baud <= AVS_REQ.writedata[7:0];
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_rd_at(logic [5:0] a);
    rdone && AVS_REQ.address == a;
  endsequence

  sequence s_en_write;
    wdone && AVS_REQ.address == ADDR_TRANSMIT_STATUS_CONTROL
      && AVS_REQ.writedata[BIT_TRANSMIT_ENABLE];
  endsequence

  sequence s_req_start;
    $rose(rq);
  endsequence

  a_wait_one_cycle: assert property (s_req_start |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("waitrequest not held for exactly one cycle");
  a_idle_no_wait: assert property (!rq |-> !AVS_WAITREQUEST)
    else $error("waitrequest high without a request");
  a_read_data_hold: assert property ($past(RSTN) && !$past(AVS_REQ.read)
    |-> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  a_upper_bits_zero: assert property (AVS_READDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (rdone && (AVS_REQ.address >= ADDR_RECEIVE_BUFFER
    || AVS_REQ.address[1:0] != 2'h0) |-> AVS_READDATA == 32'h00000000)
    else $error("unmapped or receive buffer read not zero");
  a_ien_read_back: assert property (s_rd_at(ADDR_PERIPHERAL_IRQ_ENABLE_1)
    |-> AVS_READDATA[7:0] == sh_ien)
    else $error("irq enable read back differs");
  a_pol_read_back: assert property (s_rd_at(ADDR_BAUD_CONTROL)
    |-> (AVS_READDATA[7:0] & 8'h38) == (sh_baud & 8'h38))
    else $error("polarity or width bits read back differ");
  a_line_after_reset: assert property ($rose(RSTN) |-> TRANSMIT_LINE)
    else $error("transmit line not high after reset");
  a_enable_sets_empty: assert property (s_en_write ##[1:3]
    s_rd_at(ADDR_PERIPHERAL_FLAGS_1) |-> AVS_READDATA[BIT_TX_BUFFER_EMPTY])
    else $error("buffer empty flag clear after transmit enable");
endmodule

bind uab_top uab_props u_props (.CLK(CLK), .RSTN(RSTN), .AVS_REQ(AVS_REQ),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .RECEIVE_LINE(RECEIVE_LINE), .TRANSMIT_LINE(TRANSMIT_LINE));

/* File: tb/uab_remote.sv */
`timescale 1ns/100ps
module uab_remote
#(
  parameter int TX_BIT = 16
)
(
  input  wire logic  clk,
  input  wire logic  rx_inv,
  input  wire logic  tx_inv,
  input  wire logic  tx_line,
  output logic       rx_line,
  output logic [8:0] got,
  output logic       got_ok
);
  logic drive;
  logic lvl;
  int   i;

  assign rx_line = drive ^ rx_inv;
  assign lvl     = tx_line ^ tx_inv;

  initial
  begin
    drive  = 1'b1;
  end

  // one frame: start, eight bits lsb first, stop; caller sits on a rising edge
  task automatic send(input logic [7:0] b, input int bit_clk);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int j = 0; j < 10; j++)
    begin
      drive <= fr[j];
      repeat (bit_clk) @(posedge clk);
    end
  endtask

  // decoder: start confirmed at half bit, then nine samples mid-bit
  always
  begin
    @(posedge clk);
    got_ok <= 1'b0;
    if (lvl === 1'b0)
    begin
      repeat (TX_BIT / 2) @(posedge clk);
      if (lvl === 1'b0)
      begin
        for (i = 0; i < 9; i++)
        begin
          repeat (TX_BIT) @(posedge clk);
          got[i] <= lvl;
        end
        got_ok <= 1'b1;
        @(posedge clk);
        got_ok <= 1'b0;
        while (lvl !== 1'b1) @(posedge clk);
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import uab_pkg::*;
  logic         CLK;
  logic         RSTN;
  uab_avs_req_s req;
  logic [31:0]  rdata;
  logic         wait_rq;
  logic         rx_line;
  logic         tx_line;
  logic         rx_inv;
  logic         tx_inv;
  logic [8:0]   got;
  logic         got_ok;
  logic [8:0]   exp_q[$];
  logic [7:0]   q;
  logic [7:0]   d;
  int           error_cnt;
  int           num_checks;
  int           seed;
  int           k;
  int           p;

  uab_top uut (.CLK(CLK), .RSTN(RSTN), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .RECEIVE_LINE(rx_line), .TRANSMIT_LINE(tx_line));
  uab_remote #(.TX_BIT(16)) far (.clk(CLK), .rx_inv(rx_inv), .tx_inv(tx_inv),
    .tx_line(tx_line), .rx_line(rx_line), .got(got), .got_ok(got_ok));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one access; entered and left on a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] dw);
    req <= '{!w, w, a, {24'h000000, dw}, 4'hF};
    @(posedge CLK);
    while (wait_rq !== 1'b0) @(posedge CLK);
    q = rdata[7:0];
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] dw);
    bus(1'b1, a, dw);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, q & m});
  endtask

  task automatic txb(input logic [7:0] b, input logic b8);
    exp_q.push_back({b8, b});
    wr(ADDR_TRANSMIT_BUFFER, b);
  endtask

  task automatic drain();
    while (exp_q.size() != 0) @(posedge CLK);
    repeat (40) @(posedge CLK);
  endtask

  // result watcher: each decoded frame takes the oldest expectation
  always @(posedge CLK)
    if (got_ok === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected frame", 16'hFFFF, {7'h00, got});
      else
        chk("frame", {7'h00, exp_q.pop_front()}, {7'h00, got});
    end

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial
  begin
    #600000;
    error_cnt++;
    results();
  end

  initial
  begin
    req        = '0;
    RSTN       = 1'b0;
    rx_inv     = 1'b0;
    tx_inv     = 1'b0;
    seed       = 32'h6FF6;
    error_cnt  = 0;
    num_checks = 0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    for (k = 0; k < 10; k++)
      rd(6'(k * 4), (k == 4) ? 8'hFD : 8'hFF, 8'h00, "reset value");
    chk("idle line", 16'h0001, {15'h0000, tx_line});
    d = 8'($random(seed));
    wr(ADDR_PERIPHERAL_IRQ_ENABLE_1, d);
    rd(ADDR_PERIPHERAL_IRQ_ENABLE_1, 8'hFF, d, "irq enable");
    wr(ADDR_BAUD_CONTROL, 8'h80);
    rd(ADDR_BAUD_CONTROL, 8'h80, 8'h80, "overflow set");
    wr(ADDR_BAUD_CONTROL, 8'h00);
    rd(ADDR_BAUD_CONTROL, 8'h80, 8'h00, "overflow clear");
    $display("test registers done");

    // every speed setting, receive polarity on odd passes
    for (k = 0; k < 4; k++)
    begin
      p = (k == 0) ? 64 : (k == 3) ? 4 : 16;
      wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
      wr(ADDR_TRANSMIT_STATUS_CONTROL, {5'h00, k[0], 2'h0});
      wr(ADDR_BAUD_CONTROL, {2'h0, k[0], 1'b0, k[1], 3'h0});
      rx_inv <= k[0];
      wr(ADDR_BAUD_DIVISOR_HIGH, 8'hAB);
      wr(ADDR_BAUD_CONTROL, {2'h0, k[0], 1'b0, k[1], 3'h1});
      far.send(8'h55, 16 * p);
      rd(ADDR_BAUD_CONTROL, 8'h01, 8'h00, "autobaud enable");
      rd(ADDR_BAUD_DIVISOR_HIGH, 8'hFF, 8'h00, "count high");
      bus(1'b0, ADDR_BAUD_DIVISOR_LOW, 8'h00);
      chk("count low in range", 16'h0001, {15'h0000, (q >= 8'h0F && q <= 8'h11)});
      rd(ADDR_PERIPHERAL_FLAGS_1, 8'h20, 8'h20, "receive done set");
      rd(ADDR_RECEIVE_BUFFER, 8'hFF, 8'h00, "receive buffer");
      rd(ADDR_PERIPHERAL_FLAGS_1, 8'h20, 8'h00, "receive done clear");
    end
    // wake enable: the break byte is skipped and the next byte measured
    wr(ADDR_BAUD_CONTROL, 8'h2B);
    far.send(8'h00, 64);
    rd(ADDR_BAUD_CONTROL, 8'h02, 8'h00, "wake cleared");
    far.send(8'h55, 64);
    rd(ADDR_BAUD_CONTROL, 8'h01, 8'h00, "autobaud after break");
    bus(1'b0, ADDR_BAUD_DIVISOR_LOW, 8'h00);
    chk("count after break", 16'h0001, {15'h0000, (q >= 8'h0F && q <= 8'h11)});
    // no measurement in synchronous mode
    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h14);
    wr(ADDR_BAUD_CONTROL, 8'h29);
    far.send(8'h55, 64);
    rd(ADDR_BAUD_CONTROL, 8'h01, 8'h01, "autobaud idle in sync mode");
    $display("test autobaud done");

    wr(ADDR_BAUD_CONTROL, 8'h28);
    wr(ADDR_BAUD_DIVISOR_HIGH, 8'h00);
    wr(ADDR_BAUD_DIVISOR_LOW, 8'h03);
    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h24);
    rd(ADDR_PERIPHERAL_FLAGS_1, 8'h10, 8'h10, "empty on enable");
    wr(ADDR_PERIPHERAL_FLAGS_1, 8'h00);
    rd(ADDR_PERIPHERAL_FLAGS_1, 8'h10, 8'h10, "empty not clearable");
    rd(ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02, "shifter empty");
    txb(8'($random(seed)), 1'b1);
    txb(8'($random(seed)), 1'b1);
    rd(ADDR_PERIPHERAL_FLAGS_1, 8'h10, 8'h00, "buffer held");
    rd(ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h00, "shifter busy");
    drain();
    rd(ADDR_PERIPHERAL_FLAGS_1, 8'h10, 8'h10, "empty after frames");
    rd(ADDR_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02, "shifter idle");
    $display("test back to back done");

    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h65);
    txb(8'($random(seed)), 1'b1);
    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h64);
    txb(8'($random(seed)), 1'b0);
    drain();
    $display("test nine bit done");

    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h24);
    wr(ADDR_BAUD_CONTROL, 8'h38);
    tx_inv <= 1'b1;
    repeat (4) @(posedge CLK);
    chk("inverted idle line", 16'h0000, {15'h0000, tx_line});
    txb(8'($random(seed)), 1'b1);
    drain();
    $display("test polarity done");
    results();
  end
endmodule
